// ### design/owt_top.sv
/*
 * owt_top: operation watchdog timer with APB register slave.
 * Assumes one 100 MHz pclk, sleep and debug levels from same-clock
 * logic, and the low frequency oscillator arriving as a plain pin.
 */
// Decided for this implementation: the register addresses and the APB slave port.
// Overview of operation
// - The counter runs only while the enable bit of the option register is set.
// - Any write to the reset cause address clears the counter and leaves the reset cause register unchanged.
// - Reaching the selected overflow count unserviced asserts a system reset.
// - The clock select bit picks the oscillator (0) or the bus clock (1).
// - Oscillator codes 0 to 5 give 2^5 to 2^10, codes 6 and 7 give 2^11.
// - Bus clock codes 0 to 6 give 2^13 to 2^19, code 7 also 2^19.
// - Every reset restores enabled state and default settings.
// - The option register takes only the first write after reset.
// - The counter is suspended in halted debug and both sleep levels.
// - Sleep entry clears the counter while enabled; exit resumes after 3 source clocks.
// - A watchdog reset sets the watchdog flag of the reset cause register.
`timescale 1ns/1ps
module owt_top (
    // apb clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // oscillator pin
    input  wire logic        low_freq_oscillator,
    // processor states, same clock domain
    input  wire logic        halted_debug_state,
    input  wire logic        deepest_sleep_level,
    input  wire logic        light_sleep_level,
    // reset from any other source, one-cycle pulse
    input  wire logic        other_reset_event,
    // outputs
    output logic             system_reset_req,
    output logic             irq
);

    typedef enum logic [1:0] {
        OWT_RUN,
        OWT_ASLEEP,
        OWT_RESTART
    } owt_state_t;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic                          watchdog_enable_bit;
    logic                          watchdog_clock_select;
    logic [2:0]                    watchdog_period_select;
    logic                          option_locked_reg;
    logic [1:0]                    bus_clock_divider_select;
    logic [2:0]                    reset_cause_reg;
    logic [owt_pkg::IRQ_W-1:0]     irq_status_reg;
    logic [owt_pkg::IRQ_W-1:0]     irq_mask_reg;
    logic [owt_pkg::IRQ_W-1:0]     irq_set;
    logic [owt_pkg::IRQ_W-1:0]     irq_clr;
    owt_state_t                    state_reg;
    owt_state_t                    state_next;
    logic [1:0]                    restart_cnt_reg;
    logic [3:0]                    hold_cnt_reg;
    logic [owt_pkg::BUSDIV_W-1:0]  busdiv_cnt_reg;
    logic                          bus_tick;
    logic                          lfo_tick;
    logic                          src_tick;
    logic                          asleep;
    logic                          asleep_prev_reg;
    logic                          sleep_entry;
    logic                          counting;
    logic                          service_write;
    logic                          counter_clear;
    logic                          soft_reset;
    logic                          timeout;
    logic [owt_pkg::CNT_W-1:0]     count;
    logic [owt_pkg::EXP_W-1:0]     limit_exp;
    logic                          acc_done;
    logic                          wr_done;
    logic                          addr_ok;
    logic [31:0]                   rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // apb decode: one wait state, answer registered

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == owt_pkg::OFS_RESET_CAUSE) ||
               (a == owt_pkg::OFS_SYS_OPTION)  ||
               (a == owt_pkg::OFS_IRQ_STATUS)  ||
               (a == owt_pkg::OFS_IRQ_MASK)    ||
               (a == owt_pkg::OFS_BUS_DIVIDER) ||
               (a == owt_pkg::OFS_COUNT);
    endfunction : is_mapped

    assign addr_ok  = is_mapped(paddr);
    assign acc_done = psel & penable & pready;
    assign wr_done  = acc_done & pwrite & addr_ok;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            owt_pkg::OFS_RESET_CAUSE: rd_mux[2:0] = reset_cause_reg;
            owt_pkg::OFS_SYS_OPTION: begin
                rd_mux[owt_pkg::OPT_ENABLE_BIT] = watchdog_enable_bit;
                rd_mux[owt_pkg::OPT_CLKSEL_BIT] = watchdog_clock_select;
                rd_mux[owt_pkg::OPT_PERIOD_LSB +: owt_pkg::OPT_PERIOD_W] =
                    watchdog_period_select;
            end
            owt_pkg::OFS_IRQ_STATUS:  rd_mux[1:0] = irq_status_reg;
            owt_pkg::OFS_IRQ_MASK:    rd_mux[1:0] = irq_mask_reg;
            owt_pkg::OFS_BUS_DIVIDER: rd_mux[1:0] = bus_clock_divider_select;
            owt_pkg::OFS_COUNT:       rd_mux[19:0] = count;
            default:                  rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            if (psel && penable && !pready) begin
                pready  <= 1'b1;
                pslverr <= ~addr_ok;
                prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // service write and internal reset

    // data is ignored, only the address matters
    assign service_write = wr_done &&
                           (paddr == owt_pkg::OFS_RESET_CAUSE);
    assign soft_reset    = timeout | other_reset_event;

    // reset output is stretched so the rest of the chip sees it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_reg     <= 4'h0;
            system_reset_req <= 1'b0;
        end else if (timeout) begin
            hold_cnt_reg     <= owt_pkg::RESET_HOLD;
            system_reset_req <= 1'b1;
        end else if (hold_cnt_reg != 4'h0) begin
            hold_cnt_reg     <= hold_cnt_reg - 4'h1;
            system_reset_req <= 1'b1;
        end else begin
            system_reset_req <= 1'b0;
        end
    end

    // flag survives the watchdog reset so software can see the cause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_cause_reg <= 3'h1;
        end else if (timeout) begin
            reset_cause_reg <= 3'h2;
        end else if (other_reset_event) begin
            reset_cause_reg <= 3'h4;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write-once option register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_enable_bit    <= owt_pkg::DEF_ENABLE;
            watchdog_clock_select  <= owt_pkg::DEF_CLKSEL;
            watchdog_period_select <= owt_pkg::DEF_PERIOD;
            option_locked_reg      <= 1'b0;
        end else if (soft_reset) begin
            watchdog_enable_bit    <= owt_pkg::DEF_ENABLE;
            watchdog_clock_select  <= owt_pkg::DEF_CLKSEL;
            watchdog_period_select <= owt_pkg::DEF_PERIOD;
            option_locked_reg      <= 1'b0;
        end else if (wr_done && paddr == owt_pkg::OFS_SYS_OPTION &&
                     !option_locked_reg) begin
            watchdog_enable_bit    <= pwdata[owt_pkg::OPT_ENABLE_BIT];
            watchdog_clock_select  <= pwdata[owt_pkg::OPT_CLKSEL_BIT];
            watchdog_period_select <=
                pwdata[owt_pkg::OPT_PERIOD_LSB +: owt_pkg::OPT_PERIOD_W];
            option_locked_reg      <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_clock_divider_select <= owt_pkg::DEF_BUSDIV;
        end else if (soft_reset) begin
            bus_clock_divider_select <= owt_pkg::DEF_BUSDIV;
        end else if (wr_done && paddr == owt_pkg::OFS_BUS_DIVIDER) begin
            bus_clock_divider_select <= pwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counting clock sources

    // bus clock is pclk divided by 1, 2, 4 or 8 for codes 0..3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busdiv_cnt_reg <= '0;
        end else begin
            busdiv_cnt_reg <= busdiv_cnt_reg + owt_pkg::BUSDIV_W'(1);
        end
    end

    always_comb begin
        case (bus_clock_divider_select)
            2'h0:    bus_tick = 1'b1;
            2'h1:    bus_tick = (busdiv_cnt_reg[0] == 1'b1);
            2'h2:    bus_tick = (busdiv_cnt_reg[1:0] == 2'h3);
            default: bus_tick = (busdiv_cnt_reg == 3'h7);
        endcase
    end

    owt_sync_edge u_lfo_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .async_in   (low_freq_oscillator),
        .rise_pulse (lfo_tick)
    );

    assign src_tick  = watchdog_clock_select ? bus_tick : lfo_tick;
    assign limit_exp = owt_pkg::overflow_exp(watchdog_clock_select,
                                             watchdog_period_select);
    // the same function caps bus codes at the top count

    ////////////////////////////////////////////////////////////////////////
    // sleep handling

    assign asleep = deepest_sleep_level | light_sleep_level;
    assign sleep_entry = asleep & ~asleep_prev_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            asleep_prev_reg <= 1'b0;
        end else begin
            asleep_prev_reg <= asleep;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            OWT_RUN: begin
                if (asleep) begin
                    state_next = OWT_ASLEEP;
                end
            end
            OWT_ASLEEP: begin
                if (!asleep) begin
                    state_next = OWT_RESTART;
                end
            end
            OWT_RESTART: begin
                if (asleep) begin
                    state_next = OWT_ASLEEP;
                end else if (src_tick &&
                             restart_cnt_reg == owt_pkg::RESTART_TICKS -
                             2'h1) begin
                    state_next = OWT_RUN;
                end
            end
            default: state_next = OWT_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg       <= OWT_RUN;
            restart_cnt_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            if (state_reg != OWT_RESTART) begin
                restart_cnt_reg <= 2'h0;
            end else if (src_tick) begin
                restart_cnt_reg <= restart_cnt_reg + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog counter

    // debug halts counting but keeps the value
    assign counting = watchdog_enable_bit &&
                      state_reg == OWT_RUN && !asleep &&
                      !halted_debug_state;
    // a single-cycle clear per write; the tick source is only sampled
    // on pclk so no crossing of the clear is needed
    assign counter_clear = service_write | soft_reset |
                           (sleep_entry & watchdog_enable_bit);

    owt_counter u_counter (
        .pclk      (pclk),
        .presetn   (presetn),
        .clear     (counter_clear),
        .run       (counting),
        .tick      (src_tick),
        .limit_exp (limit_exp),
        .count     (count),
        .overflow  (timeout)
    );

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, mask and output

    assign irq_set = {service_write, timeout};
    assign irq_clr = (wr_done && paddr == owt_pkg::OFS_IRQ_STATUS) ?
                     pwdata[owt_pkg::IRQ_W-1:0] : '0;

    // set beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= '0;
        end else if (wr_done && paddr == owt_pkg::OFS_IRQ_MASK) begin
            irq_mask_reg <= pwdata[owt_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

endmodule : owt_top

// ### design/owt_pkg.sv
/*
 * owt_pkg: shared constants for the operation watchdog timer.
 * Assumes a 32-bit APB register bus and a single 100 MHz pclk.
 */
package owt_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_RESET_CAUSE = 8'h00;
    localparam logic [7:0] OFS_SYS_OPTION  = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h0c;
    localparam logic [7:0] OFS_BUS_DIVIDER = 8'h10;
    localparam logic [7:0] OFS_COUNT       = 8'h14;

    // system_option_reg fields
    localparam int OPT_ENABLE_BIT  = 0;
    localparam int OPT_CLKSEL_BIT  = 1;
    localparam int OPT_PERIOD_LSB  = 2;
    localparam int OPT_PERIOD_W    = 3;

    // defaults restored by every reset
    localparam logic       DEF_ENABLE = 1'b1;
    localparam logic       DEF_CLKSEL = 1'b0;
    localparam logic [2:0] DEF_PERIOD = 3'h7;
    localparam logic [1:0] DEF_BUSDIV = 2'h0;

    // reset_cause_reg fields
    localparam int CAUSE_POWERON_BIT  = 0;
    localparam int CAUSE_WATCHDOG_BIT = 1;
    localparam int CAUSE_OTHER_BIT    = 2;

    // interrupt status / mask fields
    localparam int IRQ_TIMEOUT_BIT = 0;
    localparam int IRQ_SERVICE_BIT = 1;
    localparam int IRQ_W           = 2;

    // counting and timing
    localparam int         CNT_W          = 20;
    localparam int         EXP_W          = 5;
    localparam logic [4:0] LFO_EXP_BASE   = 5'h05;
    localparam logic [4:0] LFO_EXP_MAX    = 5'h0b;
    localparam logic [4:0] BUS_EXP_BASE   = 5'h0d;
    localparam logic [4:0] BUS_EXP_MAX    = 5'h13;
    localparam logic [1:0] RESTART_TICKS  = 2'h3;
    localparam logic [3:0] RESET_HOLD     = 4'hf;
    localparam int         BUSDIV_W       = 3;

    // overflow count exponent for a clock source and period code
    function automatic logic [EXP_W-1:0] overflow_exp(
        input logic       clksel,
        input logic [2:0] period);
        logic [EXP_W-1:0] e;
        e = 5'h00;
        if (clksel) begin
            e = BUS_EXP_BASE + {2'h0, period};
            if (e > BUS_EXP_MAX) begin
                e = BUS_EXP_MAX;
            end
        end else begin
            e = LFO_EXP_BASE + {2'h0, period};
            if (e > LFO_EXP_MAX) begin
                e = LFO_EXP_MAX;
            end
        end
        return e;
    endfunction : overflow_exp

endpackage : owt_pkg

// ### design/owt_sync_edge.sv
/*
 * owt_sync_edge: two-flop synchroniser with a rising-edge pulse.
 * Assumes the input is asynchronous to pclk and slower than pclk / 2.
 */
`timescale 1ns/1ps
module owt_sync_edge (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pin side
    input  wire logic async_in,
    // clock side
    output logic      rise_pulse
);

    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg   <= 1'b0;
            rise_pulse <= 1'b0;
        end else begin
            prev_reg   <= sync_reg;
            rise_pulse <= sync_reg & ~prev_reg;
        end
    end

endmodule : owt_sync_edge

// ### design/owt_counter.sv
/*
 * owt_counter: watchdog count with clear, hold and overflow detect.
 * Assumes tick is a one-cycle enable on pclk; clear wins over counting.
 */
`timescale 1ns/1ps
module owt_counter (
    // clock and reset
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    // control
    input  wire logic                            clear,
    input  wire logic                            run,
    input  wire logic                            tick,
    input  wire logic [owt_pkg::EXP_W-1:0]       limit_exp,
    // status
    output logic      [owt_pkg::CNT_W-1:0]       count,
    output logic                                 overflow
);

    logic [owt_pkg::CNT_W-1:0] last_val;

    assign last_val = (owt_pkg::CNT_W'(1) << limit_exp) - owt_pkg::CNT_W'(1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count    <= '0;
            overflow <= 1'b0;
        end else begin
            overflow <= 1'b0;
            if (clear) begin
                count <= '0;
            end else if (run && tick) begin
                if (count >= last_val) begin
                    count    <= '0;
                    overflow <= 1'b1;
                end else begin
                    count <= count + owt_pkg::CNT_W'(1);
                end
            end
        end
    end

endmodule : owt_counter

// ### verification/owt_checker.sv
/*
 * owt_checker: apb handshake and reset pulse properties of owt_top.
 * Assumes it is bound to owt_top and sees only that module's ports.
 */
`timescale 1ns/1ps
module owt_checker (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // watchdog
    input wire logic        system_reset_req
);
    logic [4:0] hi_cnt;

    // length of the current reset request, judged at its falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            hi_cnt <= 5'h00;
        else
            hi_cnt <= system_reset_req ? hi_cnt + 5'h01 : 5'h00;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////
    property p_rdy_wait;
        psel && $rose(penable) |-> !pready ##1 pready;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait)
        else $error("pready not one wait state after penable");
    property p_rdy_once;
        pready |=> !pready;
    endproperty
    a_rdy_once: assert property (p_rdy_once)
        else $error("pready longer than one cycle");
    property p_rdy_access;
        pready |-> psel && penable;
    endproperty
    a_rdy_access: assert property (p_rdy_access)
        else $error("pready outside an access phase");
    property p_err_rdy;
        pslverr |-> pready;
    endproperty
    a_err_rdy: assert property (p_err_rdy)
        else $error("pslverr without pready");
    property p_unmapped;
        pready && !pwrite && paddr > 8'h14 |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");
    property p_mapped;
        pready && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped)
        else $error("mapped access refused");
    property p_hold16;
        $fell(system_reset_req) |-> hi_cnt == 5'h10;
    endproperty
    a_hold16: assert property (p_hold16)
        else $error("reset request not 16 cycles long");
    // the counter restarts from zero, so no overflow can follow at once
    property p_rst_gap;
        $fell(system_reset_req) |-> !system_reset_req [*8];
    endproperty
    a_rst_gap: assert property (p_rst_gap)
        else $error("reset request repeated without counting");
endmodule : owt_checker

bind owt_top owt_checker i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .system_reset_req(system_reset_req));

// ### verification/testbench.sv
/*
 * testbench: self-checking bench for owt_top driven over apb.
 * Assumes a 100 MHz pclk and a free running oscillator of pclk / 8.
 */
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] A_CS = owt_pkg::OFS_RESET_CAUSE;
    localparam logic [7:0] A_OP = owt_pkg::OFS_SYS_OPTION;
    localparam logic [7:0] A_ST = owt_pkg::OFS_IRQ_STATUS;
    localparam logic [7:0] A_MK = owt_pkg::OFS_IRQ_MASK;
    localparam logic [7:0] A_BD = owt_pkg::OFS_BUS_DIVIDER;
    localparam logic [7:0] A_CT = owt_pkg::OFS_COUNT;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        dbg, deep, light, other, sys_rst, irq, err;
    logic        osc = 1'b0;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, c, lfsr;
    logic [2:0]  p;
    logic [2:0]  osc_div = 3'h0;
    int          fail_count = 0, n_checks = 0, cyc = 0, n;

    owt_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_freq_oscillator(osc),
        .halted_debug_state(dbg), .deepest_sleep_level(deep),
        .light_sleep_level(light), .other_reset_event(other),
        .system_reset_req(sys_rst), .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // oscillator and run limit; the limit covers every timeout run
    always @(posedge pclk) begin
        osc_div <= osc_div + 3'h1;
        osc <= osc_div[2];
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fail_count = fail_count + 1;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04000007 : 32'h0);
    endfunction : lfsr_next

    function automatic int exp_n(input logic cs, input logic [2:0] q);
        if (cs)
            return 1 << ((q < 3'h7) ? 13 + q : 19);
        return 1 << ((q < 3'h6) ? 5 + q : 11);
    endfunction : exp_n

    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wrap_up();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    // idle cycle first, so psel is never assigned twice in one step
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_rst(input int lo, hi);
        n = 0;
        while (sys_rst !== 1'b1 && n < 40000) begin
            @(posedge pclk);
            n++;
        end
        chk("timeout", {31'h0, n >= lo && n <= hi}, 32'h1);
    endtask : wait_rst

    // lo and hi allow for tick phase and oscillator sync delay
    task automatic run_to(input logic [31:0] opt, input int d, e);
        apb(1'b1, A_OP, opt);
        lfsr = lfsr_next(lfsr);
        apb(1'b1, A_CS, lfsr);
        wait_rst(e * d - d, e * d + 4 * d + 4);
        repeat (20) @(posedge pclk);
        apb(1'b0, A_CS, 32'h0);
        chk("cause_wd", {31'h0, rd[1]}, 32'h1);
    endtask : run_to

    ////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, dbg, deep} = 6'h0;
        {light, other, paddr, pwdata} = '0;
        lfsr = 32'h00010cda;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_CS, 32'h0);
        chk("cause_por", rd, 32'h1);
        apb(1'b0, A_OP, 32'h0);
        chk("opt_def", rd, 32'h1d);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        apb(1'b1, A_OP, 32'h0);
        apb(1'b1, A_OP, 32'h3);
        apb(1'b0, A_OP, 32'h0);
        chk("opt_lock", rd, 32'h0);
        // the count ran from reset until the disabling write: it must freeze
        apb(1'b0, A_CT, 32'h0);
        c = rd;
        repeat (200) @(posedge pclk);
        apb(1'b0, A_CT, 32'h0);
        chk("cnt_off", rd, c);
        other <= 1'b1;
        @(posedge pclk);
        other <= 1'b0;
        apb(1'b0, A_OP, 32'h0);
        chk("opt_other", rd, 32'h1d);
        apb(1'b1, A_MK, 32'h1);
        for (int bd = 0; bd < 2; bd++) begin
            apb(1'b1, A_BD, 32'(bd));
            run_to(32'h3, 1 << bd, exp_n(1'b1, 3'h0));
        end
        chk("irq_on", {31'h0, irq}, 32'h1);
        apb(1'b0, A_ST, 32'h0);
        chk("st_to", {31'h0, rd[0]}, 32'h1);
        apb(1'b1, A_MK, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq_mask", {31'h0, irq}, 32'h0);
        apb(1'b1, A_MK, 32'h1);
        apb(1'b1, A_ST, 32'h3);
        repeat (2) @(posedge pclk);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        run_to(32'h19, 8, exp_n(1'b0, 3'h6));
        for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            p = 3'(lfsr[7:0] % 3);
            run_to({27'h0, p, 2'h1}, 8, exp_n(1'b0, p));
        end
        apb(1'b1, A_OP, 32'h3);
        apb(1'b0, A_CS, 32'h0);
        c = rd;
        lfsr = lfsr_next(lfsr);
        apb(1'b1, A_CS, lfsr);
        apb(1'b0, A_CS, 32'h0);
        chk("cause_ro", rd, 32'h2);
        apb(1'b0, A_CT, 32'h0);
        chk("cnt_svc", {31'h0, rd < 32'h8}, 32'h1);
        // divide by 8: 82 edges between service and capture give 10 or 11
        apb(1'b1, A_BD, 32'h3);
        apb(1'b1, A_CS, 32'h0);
        repeat (80) @(posedge pclk);
        apb(1'b0, A_CT, 32'h0);
        c = {31'h0, rd >= 32'h0a && rd <= 32'h0b};
        chk("cnt_div8", c, 32'h1);
        apb(1'b1, A_BD, 32'h0);
        repeat (50) @(posedge pclk);
        dbg <= 1'b1;
        apb(1'b0, A_CT, 32'h0);
        c = rd;
        repeat (30) @(posedge pclk);
        apb(1'b0, A_CT, 32'h0);
        chk("cnt_dbg", rd, c);
        dbg <= 1'b0;
        light <= 1'b1;
        repeat (20) @(posedge pclk);
        apb(1'b0, A_CT, 32'h0);
        chk("cnt_light", rd, 32'h0);
        light <= 1'b0;
        repeat (40) @(posedge pclk);
        deep <= 1'b1;
        repeat (20) @(posedge pclk);
        apb(1'b0, A_CT, 32'h0);
        chk("cnt_deep", rd, 32'h0);
        deep <= 1'b0;
        wait_rst(8192 + 4, 8192 + 9);
        wrap_up();
    end
endmodule : testbench
